// ==== src/gpio_ports_abc.sv ====
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "gpio_ports_abc_regs.svh"

// What this block does
// - Port A direction 1 drives, readable/writable
// - Reset clears port A direction bits
// - Port A read: latch if output, else pin
// - Data writes with wb_sel_i[0] set update the latch in either direction
// - Port A pullup bits, independently writable
// - Pullup forced off while pin outputs
// - Port B six pins, latch and direction
// - Reset keeps port B latches
// - Selected analog channel overrides port B pin
// - Port B direction 1 drives, reset clears
// - Port B read: latch if output, else pin
// - Port C two pins, latch, direction, pullup
// - Reset keeps port C latches, clears direction
// - Port C read and direction like A
// - Port C pullup applies only to inputs
// - Port A latches survive reset; unused bits zero
module gpio_ports_abc #(
    parameter int PORT_A_PINS = `PORT_A_WIDTH,
    parameter int PORT_B_PINS = `PORT_B_WIDTH,
    parameter int PORT_C_PINS = `PORT_C_WIDTH
) (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [3:0]                    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    input  wire gpio_ports_abc_pkg::pin_vec_t  pinIn,
    output gpio_ports_abc_pkg::pin_vec_t       pinOut,
    output gpio_ports_abc_pkg::pin_vec_t       pinOe,
    output gpio_ports_abc_pkg::pin_vec_t       pullupOn,
    output logic      [5:0]                    analogSelect
);

    // ------------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------------
    // The pin vector type fixes the field widths, so only the default pin counts can be served.
    if (PORT_A_PINS != `PORT_A_WIDTH || PORT_B_PINS != `PORT_B_WIDTH || PORT_C_PINS != `PORT_C_WIDTH) begin : g_pin_check
        $error("Pin counts must match the pin vector type.");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    gpio_ports_abc_pkg::pin_vec_t latch_r,  latch_nxt;
    gpio_ports_abc_pkg::pin_vec_t dir_r,    dir_nxt;
    logic [3:0]                   puA_r,    puA_nxt;
    logic [1:0]                   puC_r,    puC_nxt;
    logic [5:0]                   anaSel_r, anaSel_nxt;
    gpio_ports_abc_pkg::pin_vec_t syncA_r,  syncB_r;
    gpio_ports_abc_pkg::bus_state_t busState_r, busState_nxt;
    logic [31:0]                  rdData_r, rdData_nxt;
    gpio_ports_abc_pkg::pin_vec_t pinOut_nxt, pinOe_nxt, pullup_nxt;
    gpio_ports_abc_pkg::pin_vec_t readView;
    logic                         wrEn;

    // ------------------------------------------------------------------------
    // Bus slave and register writes
    // ------------------------------------------------------------------------
    // One wait state: ack rises the cycle after the request and drops after.
    assign wrEn = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
                  (busState_r == gpio_ports_abc_pkg::BUS_IDLE);

    always_comb begin
        // Output bits read latch, input bits read synchronised pin.
        readView = (latch_r & dir_r) | (syncB_r & ~dir_r);
    end

    always_comb begin
        latch_nxt    = latch_r;
        dir_nxt      = dir_r;
        puA_nxt      = puA_r;
        puC_nxt      = puC_r;
        anaSel_nxt   = anaSel_r;
        rdData_nxt   = rdData_r;
        busState_nxt = gpio_ports_abc_pkg::BUS_IDLE;
        if (wb_cyc_i && wb_stb_i && busState_r == gpio_ports_abc_pkg::BUS_IDLE) begin
            busState_nxt = gpio_ports_abc_pkg::BUS_ACK;
            rdData_nxt   = 32'h0000_0000;
            case (wb_adr_i)
                `PORT_A_DATA_IDX:          rdData_nxt[3:0] = readView.portA;
                `PORT_B_DATA_IDX:          rdData_nxt[5:0] = readView.portB;
                `PORT_C_DATA_IDX:          rdData_nxt[1:0] = readView.portC;
                `PORT_A_DIRECTION_IDX:     rdData_nxt[3:0] = dir_r.portA;
                `PORT_B_DIRECTION_IDX:     rdData_nxt[5:0] = dir_r.portB;
                `PORT_C_DIRECTION_IDX:     rdData_nxt[1:0] = dir_r.portC;
                `PORT_A_PULLUP_ENABLE_IDX: rdData_nxt[3:0] = puA_r;
                `PORT_C_PULLUP_ENABLE_IDX: rdData_nxt[1:0] = puC_r;
                `ANALOG_SELECT_IDX:        rdData_nxt[5:0] = anaSel_r;
                default:                   rdData_nxt = 32'h0000_0000;
            endcase
        end
        if (wrEn) begin
            case (wb_adr_i)
                // Latches load regardless of direction.
                `PORT_A_DATA_IDX:          latch_nxt.portA = wb_dat_i[3:0];
                `PORT_B_DATA_IDX:          latch_nxt.portB = wb_dat_i[5:0];
                `PORT_C_DATA_IDX:          latch_nxt.portC = wb_dat_i[1:0];
                `PORT_A_DIRECTION_IDX:     dir_nxt.portA   = wb_dat_i[3:0];
                `PORT_B_DIRECTION_IDX:     dir_nxt.portB   = wb_dat_i[5:0];
                `PORT_C_DIRECTION_IDX:     dir_nxt.portC   = wb_dat_i[1:0];
                `PORT_A_PULLUP_ENABLE_IDX: puA_nxt         = wb_dat_i[3:0];
                `PORT_C_PULLUP_ENABLE_IDX: puC_nxt         = wb_dat_i[1:0];
                `ANALOG_SELECT_IDX:        anaSel_nxt      = wb_dat_i[5:0];
                default:                   latch_nxt       = latch_r;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------------
    always_comb begin
        pinOut_nxt        = latch_nxt;
        pinOe_nxt         = dir_nxt;
        // Analog selection takes the pin away from the digital driver.
        pinOe_nxt.portB   = dir_nxt.portB & ~anaSel_nxt;
        pullup_nxt        = '0;
        pullup_nxt.portA  = puA_nxt & ~dir_nxt.portA;
        pullup_nxt.portC  = puC_nxt & ~dir_nxt.portC;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Data latches carry no reset, so software values survive it.
    always_ff @(posedge clk) begin
        latch_r  <= latch_nxt;
        pinOut   <= pinOut_nxt;
        syncA_r  <= pinIn;
        syncB_r  <= syncA_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dir_r        <= '0;
            puA_r        <= 4'h0;
            puC_r        <= 2'h0;
            anaSel_r     <= 6'h00;
            busState_r   <= gpio_ports_abc_pkg::BUS_IDLE;
            rdData_r     <= 32'h0000_0000;
            pinOe        <= '0;
            pullupOn     <= '0;
            analogSelect <= 6'h00;
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h0000_0000;
        end else begin
            dir_r        <= dir_nxt;
            puA_r        <= puA_nxt;
            puC_r        <= puC_nxt;
            anaSel_r     <= anaSel_nxt;
            busState_r   <= busState_nxt;
            rdData_r     <= rdData_nxt;
            pinOe        <= pinOe_nxt;
            pullupOn     <= pullup_nxt;
            analogSelect <= anaSel_nxt;
            wb_ack_o     <= (busState_nxt == gpio_ports_abc_pkg::BUS_ACK);
            wb_dat_o     <= rdData_nxt;
        end
    end

endmodule

// ==== src/gpio_ports_abc_regs.svh ====
`ifndef GPIO_PORTS_ABC_REGS_SVH
`define GPIO_PORTS_ABC_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PORT_A_DATA_IDX          4'h0
`define PORT_B_DATA_IDX          4'h1
`define PORT_C_DATA_IDX          4'h2
`define PORT_A_DIRECTION_IDX     4'h4
`define PORT_B_DIRECTION_IDX     4'h5
`define PORT_C_DIRECTION_IDX     4'h6
`define PORT_A_PULLUP_ENABLE_IDX 4'h8
`define PORT_C_PULLUP_ENABLE_IDX 4'h9
`define ANALOG_SELECT_IDX        4'hA

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define PORT_A_WIDTH             4
`define PORT_B_WIDTH             6
`define PORT_C_WIDTH             2
`define DIRECTION_RESET          8'h00
`define PULLUP_RESET             8'h00
`define ANALOG_SELECT_RESET      8'h00

`endif

// ==== src/gpio_ports_abc_pkg.sv ====
package gpio_ports_abc_pkg;

    typedef struct packed {
        logic [3:0] portA;
        logic [5:0] portB;
        logic [1:0] portC;
    } pin_vec_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_t;

endpackage

// ==== verification/gpio_ports_abc_sva.sv ====
`timescale 1ns/1ps
// --------------------------------
// Bus and pin control properties
// --------------------------------
module gpio_ports_abc_sva (
    input wire logic                         clk,
    input wire logic                         sys_rst,
    input wire logic                         wb_cyc_i,
    input wire logic                         wb_stb_i,
    input wire logic                         wb_we_i,
    input wire logic [3:0]                   wb_adr_i,
    input wire logic [3:0]                   wb_sel_i,
    input wire logic [31:0]                  wb_dat_i,
    input wire logic [31:0]                  wb_dat_o,
    input wire logic                         wb_ack_o,
    input wire gpio_ports_abc_pkg::pin_vec_t pinOe,
    input wire gpio_ports_abc_pkg::pin_vec_t pullupOn,
    input wire logic [5:0]                   analogSelect
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    a_reset_clear: assert property ($past(sys_rst) |-> pinOe == 12'h000 && pullupOn == 12'h000)
        else $error("controls not cleared");
    a_dir_write: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h4
        |-> pinOe.portA == wb_dat_i[3:0]) else $error("direction write lost");
    a_pullup_a: assert property ((pinOe.portA & pullupOn.portA) == 4'h0) else $error("pullup on output");
    a_pullup_c: assert property ((pinOe.portC & pullupOn.portC) == 2'h0 && pullupOn.portB == 6'h00)
        else $error("bad pullup");
    a_analog_mask: assert property ((pinOe.portB & analogSelect) == 6'h00) else $error("analog pin driven");
    a_unused_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper bits set");
endmodule
bind gpio_ports_abc gpio_ports_abc_sva u_gpio_ports_abc_sva (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pinOe, .pullupOn, .analogSelect);

// ==== verification/gpio_ports_abc_tb.sv ====
`timescale 1ns/1ps
// --------------------------------
// Register and pin scenarios
// --------------------------------
module gpio_ports_abc_tb;
    logic                         clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]                   wb_adr_i, wb_sel_i;
    logic [31:0]                  wb_dat_i, wb_dat_o, rd;
    logic [5:0]                   analogSelect;
    gpio_ports_abc_pkg::pin_vec_t pinIn, pinOut, pinOe, pullupOn;
    int                           num_errors, total_checks, cycles;
    gpio_ports_abc u_gpio_ports_abc (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .pinIn, .pinOut, .pinOe, .pullupOn, .analogSelect);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // The whole run needs fewer than a hundred cycles, so the 3000-cycle limit lies far above it and only cuts off a hang.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    task automatic t_reset();
        rdchk("dirA", 4'h4, 32'h0);
        rdchk("dirB", 4'h5, 32'h0);
        rdchk("dirC", 4'h6, 32'h0);
        rdchk("unmapped", 4'hF, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_port_a();
        xfer(1'b1, 4'h0, 32'h5);
        xfer(1'b1, 4'h4, 32'h3);
        rdchk("dataA", 4'h0, 32'h9);
        rdchk("dirA", 4'h4, 32'h3);
        xfer(1'b1, 4'h8, 32'hF);
        chk("pullA", pullupOn.portA, 32'hC);
        chk("outA", pinOut.portA, 32'h5);
        $display("port A test done");
    endtask
    task automatic t_port_b();
        xfer(1'b1, 4'h1, 32'h2A);
        xfer(1'b1, 4'h5, 32'h0F);
        rdchk("dataB", 4'h1, 32'h1A);
        xfer(1'b1, 4'hA, 32'h1);
        chk("oeB", pinOe.portB, 32'h0E);
        chk("outB", pinOut.portB, 32'h2A);
        xfer(1'b1, 4'h5, 32'h3F);
        chk("oeBall", pinOe.portB, 32'h3E);
        $display("port B test done");
    endtask
    task automatic t_port_c();
        xfer(1'b1, 4'h2, 32'h2);
        xfer(1'b1, 4'h6, 32'h1);
        xfer(1'b1, 4'h9, 32'h3);
        rdchk("dataC", 4'h2, 32'h2);
        chk("pullC", pullupOn.portC, 32'h2);
        chk("oeC", pinOe.portC, 32'h1);
        $display("port C test done");
    endtask
    task automatic t_reset_keep();
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        chk("keepA", pinOut.portA, 32'h5);
        chk("keepB", pinOut.portB, 32'h2A);
        chk("keepC", pinOut.portC, 32'h2);
        rdchk("pinA", 4'h0, 32'hA);
        $display("second reset test done");
    endtask
    initial begin
        {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h0F, 32'h0};
        pinIn = 12'hA57;
        {num_errors, total_checks, cycles} = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_port_a();
        t_port_b();
        t_port_c();
        t_reset_keep();
        close_out();
    end
endmodule
